/* File: bmc_consts.vh */
/*
 * Constants for the boot mapping control block: register offsets, field
 * positions, reset values and clock rates.
 * Assumes it is included by bare name from the block's design files.
 */
`ifndef BMC_CONSTS_VH
`define BMC_CONSTS_VH

// ****************************************************************
// Register word offsets (byte addresses, one word each)
// ****************************************************************
`define BMC_AUX_IDX        8'hA2
`define BMC_ADDR_AUX       10'h288
`define BMC_ADDR_HWSEC     10'h290
`define BMC_ADDR_UBV       10'h294
`define BMC_ADDR_SWPROT    10'h298
`define BMC_ADDR_STATUS    10'h29C
`define BMC_ADDR_CTRL      10'h2A0

// ****************************************************************
// Auxiliary control field positions
// ****************************************************************
`define BMC_AUX_PTRSEL     0
`define BMC_AUX_ZERO       2
`define BMC_AUX_GF         3
`define BMC_AUX_MAP        5

// ****************************************************************
// Hardware security byte field positions
// ****************************************************************
`define BMC_HWSEC_DSPEED   7
`define BMC_HWSEC_JUMP     6
`define BMC_HWSEC_LOCK_HI  2

// ****************************************************************
// Control register bit positions
// ****************************************************************
`define BMC_CTRL_HWPROG    0
`define BMC_CTRL_ERASE     1

// ****************************************************************
// Reset values and vectors
// ****************************************************************
`define BMC_FUSE_ERASED    8'hFF
`define BMC_HWSEC_RESV_MASK 8'h38
`define BMC_HWSEC_SW_MASK   8'hC0
`define BMC_UBV_DEFAULT    8'hF0
`define BMC_VEC_BOOT       16'hF000
`define BMC_VEC_APP        16'h0000
`define BMC_VEC_LOW        8'h00
`define BMC_MAP_LO         16'hF000
`define BMC_MAP_HI         16'hFFFF

// ****************************************************************
// Clock rates in MHz
// ****************************************************************
`define BMC_CORE_MHZ       200
`define BMC_USB_MHZ        48

`endif

/* File: bmc_usb_clk_en.v */
/*
 * Fractional divider making a 48 MHz rate enable pulse from the core clock.
 * Assumes one core clock; the pulse stands one cycle per 48 MHz tick.
 */
`timescale 1ns/10ps
`include "bmc_consts.vh"

// ****************************************************************
// Rate enable generator
// ****************************************************************
module bmc_usb_clk_en #(
   parameter CORE_MHZ = `BMC_CORE_MHZ,
   parameter OUT_MHZ  = `BMC_USB_MHZ
) (
   input  wire       clk,
   input  wire       rstn,
   output reg        tick
);

   reg  [9:0] acc;   // Phase accumulator
   wire [10:0] sum;  // Accumulator plus step

   assign sum = {1'b0, acc} + OUT_MHZ[10:0];

   // Bresenham style divider, exact on average
   always @(posedge clk) begin
      if (!rstn) begin
         acc  <= 10'h000;
         tick <= 1'b0;
      end else if (sum >= CORE_MHZ[10:0]) begin
         acc  <= sum[9:0] - CORE_MHZ[9:0];
         tick <= 1'b1;
      end else begin
         acc  <= sum[9:0];
         tick <= 1'b0;
      end
   end

endmodule // bmc_usb_clk_en

/* File: bmc_boot_map.v */
/*
 * Boot mapping control: reset vector choice, boot flash map window,
 * auxiliary control register and the nonvolatile configuration bytes.
 * Assumes an Avalon-MM master on the core clock; fuse bytes are held in
 * flops here and stand for the nonvolatile cells, erased value all ones.
 */
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "bmc_consts.vh"

// Behaviour
// - Low boot pin at reset maps boot, F000h
// - Programmed jump fuse maps boot, vector F000h
// - Aux bit 5 maps boot flash F000h-FFFFh
// - Aux bit 2 reads zero, ignores writes
// - Aux bit 0 picks second data pointer
// - Aux bit 3 is plain software flag
// - Aux reserved bits undefined, software writes zero
// - Double speed fuse selects double speed start
// - Reset copies double speed fuse into clock bit
// - Erased jump fuse starts application at 0000h
// - Security byte reserved bits read unprogrammed
// - Lock nibble writable only in hardware mode
// - Full erase sets all config bytes unprogrammed
// - Boot vector byte holds loader address high
// - Upgrade traffic uses endpoint 0, 32 bytes
// - USB clock 48 MHz from crystal; here a 48 MHz rate tick divided from the core clock
// - Unprogrammed fuse reads one, programmed zero
// - User loader starts at byte then 00h
module bmc_boot_map #(
   parameter EP0_MAX_PACKET = 32
) (
   input  wire        clk,
   input  wire        rstn,
   input  wire [9:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   output reg  [1:0]  avs_response,
   input  wire        boot_request_pin_n,
   input  wire [15:0] code_addr,
   output reg         boot_flash_sel,
   output reg  [15:0] reset_vector,
   output reg  [15:0] user_loader_addr,
   output reg         data_pointer_select,
   output reg         double_speed_bit,
   output reg         usb_tick,
   output reg  [7:0]  ep0_max_packet
);

   // ****************************************************************
   // State
   // ****************************************************************
   reg        boot_flash_map_enable;  // Aux bit 5
   reg        general_flag;           // Aux bit 3
   reg  [1:0] aux_resv_hi;            // Aux bits 7-6, plain storage
   reg        aux_resv_4;             // Aux bit 4, plain storage
   reg        aux_dp_ext;             // Aux bit 1, reserved extension
   reg  [7:0] hardware_security_byte; // Fuse byte, erased = ones
   reg  [7:0] user_boot_vector;       // Loader address high byte
   reg  [7:0] software_protect_byte;  // Loader protection byte
   reg        hw_prog_mode;           // Hardware programming mode
   reg        boot_by_pin;            // Pin seen low at last reset
   reg        in_reset_d;             // Reset seen last cycle
   reg        ack_phase;              // Second cycle of an access
   reg  [7:0] next_rdata;             // Read mux result
   reg        next_hit;               // Address decodes
   wire       usb_tick_raw;           // Divider pulse
   wire [7:0] aux_view;               // Aux register as read
   wire [7:0] hwsec_view;             // Security byte as read
   wire       wr_take;                // Write completes this edge
   wire       jump_fuse_prog;         // Jump fuse programmed

   // ****************************************************************
   // USB rate enable
   // ****************************************************************
   bmc_usb_clk_en #(
      .CORE_MHZ (`BMC_CORE_MHZ),
      .OUT_MHZ  (`BMC_USB_MHZ)
   ) u_usb_en (
      .clk  (clk),
      .rstn (rstn),
      .tick (usb_tick_raw)
   );

   // ****************************************************************
   // Read views
   // ****************************************************************
   // Bit 2 held at zero so an increment cannot carry into bit 3
   assign aux_view = {aux_resv_hi, boot_flash_map_enable, aux_resv_4,
                      general_flag, 1'b0, aux_dp_ext,
                      data_pointer_select};
   // Reserved bits always read unprogrammed
   assign hwsec_view = hardware_security_byte | `BMC_HWSEC_RESV_MASK;
   // Programmed means zero
   assign jump_fuse_prog = ~hardware_security_byte[`BMC_HWSEC_JUMP];
   // One wait cycle, then the answer edge
   assign wr_take = avs_write & ack_phase;

   // ****************************************************************
   // Bus handshake: waitrequest high on the first cycle, low on second
   // ****************************************************************
   always @* begin
      next_hit   = 1'b1;
      next_rdata = 8'h00;
      case (avs_address)
         `BMC_ADDR_AUX:    next_rdata = aux_view;
         `BMC_ADDR_HWSEC:  next_rdata = hwsec_view;
         `BMC_ADDR_UBV:    next_rdata = user_boot_vector;
         `BMC_ADDR_SWPROT: next_rdata = software_protect_byte;
         `BMC_ADDR_STATUS: next_rdata = {5'h00, boot_by_pin, jump_fuse_prog,
                                         double_speed_bit};
         `BMC_ADDR_CTRL:   next_rdata = {7'h00, hw_prog_mode};
         default:          next_hit   = 1'b0;
      endcase
   end

   // Waitrequest drops for one cycle after each request is seen
   always @(posedge clk) begin
      if (!rstn) begin
         ack_phase       <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
         avs_response    <= 2'h0;
      end else if ((avs_read | avs_write) & ~ack_phase) begin
         ack_phase       <= 1'b1;
         avs_waitrequest <= 1'b0;
         avs_readdata    <= {24'h000000, next_rdata};
         // Unmapped address answers with a decode error
         avs_response    <= next_hit ? 2'h0 : 2'h3;
      end else begin
         ack_phase       <= 1'b0;
         avs_waitrequest <= 1'b1;
      end
   end

   // ****************************************************************
   // Reset phase detect
   // ****************************************************************
   // Straps are caught in the first cycle after release
   always @(posedge clk) begin
      if (!rstn)
         in_reset_d <= 1'b1;
      else
         in_reset_d <= 1'b0;
   end

   // ****************************************************************
   // Auxiliary control register and boot map enable
   // ****************************************************************
   always @(posedge clk) begin
      if (!rstn) begin
         boot_flash_map_enable <= 1'b0;
         general_flag          <= 1'b0;
         data_pointer_select   <= 1'b0;
         aux_resv_hi           <= 2'h0;
         aux_resv_4            <= 1'b0;
         aux_dp_ext            <= 1'b0;
         boot_by_pin           <= 1'b0;
      end else if (in_reset_d) begin
         // Pin and fuse looked at once per reset
         boot_by_pin <= ~boot_request_pin_n;
         if (~boot_request_pin_n)
            boot_flash_map_enable <= 1'b1;
         else if (jump_fuse_prog)
            boot_flash_map_enable <= 1'b1;
         else
            boot_flash_map_enable <= 1'b0;
      end else if (wr_take && avs_address == `BMC_ADDR_AUX && avs_byteenable[0]) begin
         // Software may map or unmap the boot flash at any time
         boot_flash_map_enable <= avs_writedata[`BMC_AUX_MAP];
         general_flag          <= avs_writedata[`BMC_AUX_GF];
         data_pointer_select   <= avs_writedata[`BMC_AUX_PTRSEL];
         // Reserved bits just store; their value means nothing
         aux_resv_hi           <= avs_writedata[7:6];
         aux_resv_4            <= avs_writedata[4];
         aux_dp_ext            <= avs_writedata[1];
      end
   end

   // ****************************************************************
   // Nonvolatile bytes and programming mode
   // ****************************************************************
   // Flops stand for the fuse cells, so no rstn term: contents persist
   // across resets, as nonvolatile storage must. Start value is erased, but F0h for the boot vector byte.
   initial hardware_security_byte = `BMC_FUSE_ERASED;
   initial user_boot_vector       = `BMC_UBV_DEFAULT;
   initial software_protect_byte  = `BMC_FUSE_ERASED;

   always @(posedge clk) begin
      if (wr_take && avs_address == `BMC_ADDR_CTRL && avs_byteenable[0] &&
          avs_writedata[`BMC_CTRL_ERASE] && hw_prog_mode) begin
         // Full erase returns every byte to unprogrammed
         hardware_security_byte <= `BMC_FUSE_ERASED;
         user_boot_vector       <= `BMC_FUSE_ERASED;
         software_protect_byte  <= `BMC_FUSE_ERASED;
      end else if (wr_take && avs_byteenable[0]) begin
         if (avs_address == `BMC_ADDR_HWSEC) begin
            // Software reaches the top bits only; lock nibble needs hw mode
            if (hw_prog_mode)
               hardware_security_byte <= avs_writedata[7:0]
                                         | `BMC_HWSEC_RESV_MASK;
            else
               hardware_security_byte <=
                  (avs_writedata[7:0] & `BMC_HWSEC_SW_MASK) |
                  (hardware_security_byte & ~`BMC_HWSEC_SW_MASK);
         end
         if (avs_address == `BMC_ADDR_UBV)
            user_boot_vector <= avs_writedata[7:0];
         if (avs_address == `BMC_ADDR_SWPROT)
            software_protect_byte <= avs_writedata[7:0];
      end
   end

   // Programming mode bit, cleared by reset
   always @(posedge clk) begin
      if (!rstn)
         hw_prog_mode <= 1'b0;
      else if (wr_take && avs_address == `BMC_ADDR_CTRL && avs_byteenable[0])
         hw_prog_mode <= avs_writedata[`BMC_CTRL_HWPROG];
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   always @(posedge clk) begin
      if (!rstn) begin
         reset_vector     <= `BMC_VEC_APP;
         double_speed_bit <= 1'b0;
         boot_flash_sel   <= 1'b0;
         user_loader_addr <= 16'h0000;
         usb_tick         <= 1'b0;
         ep0_max_packet   <= 8'h00;
      end else begin
         if (in_reset_d) begin
            // Boot vector when pin low or jump fuse programmed
            reset_vector <= (~boot_request_pin_n | jump_fuse_prog) ?
                            `BMC_VEC_BOOT : `BMC_VEC_APP;
            // Programmed (zero) fuse means double speed
            double_speed_bit <=
               ~hardware_security_byte[`BMC_HWSEC_DSPEED];
         end
         // Window F000h..FFFFh served by boot flash when mapped
         boot_flash_sel <= boot_flash_map_enable &&
                           code_addr >= `BMC_MAP_LO &&
                           code_addr <= `BMC_MAP_HI;
         user_loader_addr <= {user_boot_vector, `BMC_VEC_LOW};
         usb_tick         <= usb_tick_raw;
         ep0_max_packet   <= EP0_MAX_PACKET[7:0];
      end
   end

endmodule // bmc_boot_map

/* File: bmc_boot_map_monitor.sv */
/* Checker for the boot mapping block: bus answers, reset vector choice,
   aux register fields and derived outputs.
   Assumes the consts header is on the include path; bound to the top. */
`timescale 1ns/10ps
`include "bmc_consts.vh"
module bmc_boot_map_monitor (
   input wire        clk,
   input wire        rstn,
   input wire [9:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire [1:0]  avs_response,
   input wire        boot_request_pin_n,
   input wire [15:0] code_addr,
   input wire        boot_flash_sel,
   input wire [15:0] reset_vector,
   input wire [15:0] user_loader_addr,
   input wire        data_pointer_select,
   input wire        double_speed_bit,
   input wire        usb_tick,
   input wire [7:0]  ep0_max_packet
);
   // ****************************************************************
   // Helper decode
   // ****************************************************************
   wire ans   = !avs_waitrequest;                      // Answer cycle
   wire w_ok  = ans && avs_write && avs_byteenable[0];  // Write that acts
   wire mapped = avs_address == `BMC_ADDR_AUX || avs_address == `BMC_ADDR_HWSEC ||
                 avs_address == `BMC_ADDR_UBV || avs_address == `BMC_ADDR_SWPROT ||
                 avs_address == `BMC_ADDR_STATUS || avs_address == `BMC_ADDR_CTRL;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_pin_boot: assert property ($rose(rstn) && !boot_request_pin_n |=> ##1
      reset_vector == 16'hF000) else $error("pin low did not give boot vector");
   a_vector_hold: assert property (rstn && $past(rstn) && $past(rstn, 2) |->
      $stable(reset_vector)) else $error("reset vector moved after capture");
   a_speed_hold: assert property (rstn && $past(rstn) && $past(rstn, 2) |->
      $stable(double_speed_bit)) else $error("double speed bit moved");
   a_map_window: assert property (boot_flash_sel |-> $past(code_addr) >= 16'hF000)
      else $error("boot flash selected outside window");
   a_aux_zero: assert property (ans && avs_read && avs_address == `BMC_ADDR_AUX |->
      avs_readdata[2] == 1'b0) else $error("aux bit 2 read as one");
   a_hwsec_resv: assert property (ans && avs_read && avs_address == `BMC_ADDR_HWSEC |->
      avs_readdata[5:3] == 3'h7) else $error("security reserved bits programmed");
   a_ptr_follow: assert property (w_ok && avs_address == `BMC_ADDR_AUX |-> ##2
      data_pointer_select == $past(avs_writedata[0], 2)) else $error("pointer select wrong");
   a_loader_addr: assert property (w_ok && avs_address == `BMC_ADDR_UBV |-> ##2
      user_loader_addr == {$past(avs_writedata[7:0], 2), 8'h00}) else $error("loader addr");
   a_tick_single: assert property (usb_tick |=> !usb_tick)
      else $error("rate tick wider than one cycle");
   a_ep0_size: assert property ($past(rstn) |-> ep0_max_packet == 8'h20)
      else $error("endpoint packet size wrong");
   a_unmapped_resp: assert property (ans && !mapped |-> avs_response == 2'b11 &&
      (avs_write || avs_readdata == 32'h0)) else $error("unmapped access not refused");
   // Main scenarios seen
   c_pin_boot: cover property ($rose(rstn) && !boot_request_pin_n);
   c_unmapped: cover property (ans && !mapped);
   c_flash_sel: cover property (boot_flash_sel);
endmodule // bmc_boot_map_monitor

bind bmc_boot_map bmc_boot_map_monitor mon (.clk, .rstn, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
   .boot_request_pin_n, .code_addr, .boot_flash_sel, .reset_vector, .user_loader_addr,
   .data_pointer_select, .double_speed_bit, .usb_tick, .ep0_max_packet);

/* File: bmc_boot_map_bench.sv */
/* Self-checking bench for the boot mapping block: bus tasks, a small
   reference model of the registers, directed and random scenarios.
   Assumes the design files and the consts header are compiled first. */
`timescale 1ns/10ps
`include "bmc_consts.vh"
module bmc_boot_map_bench;
   logic        clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic        boot_request_pin_n = 1'b1, boot;
   logic [9:0]  avs_address = 10'h000;
   logic [31:0] avs_writedata = 32'h0, rd;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [15:0] code_addr = 16'h0000, r;
   wire  [31:0] avs_readdata;
   wire  [15:0] reset_vector, user_loader_addr;
   wire  [7:0]  ep0_max_packet;
   wire  [1:0]  avs_response;
   wire         avs_waitrequest, boot_flash_sel, data_pointer_select, double_speed_bit;
   wire         usb_tick;
   logic [1:0]  rsp;
   logic [7:0]  m_aux = 8'h00, m_hwsec = 8'hFF, m_ubv = 8'hF0, m_swprot = 8'hFF;
   logic [7:0]  m_ctrl = 8'h00, d;
   integer      seed, i, n, mismatches = 0, comparisons = 0;

   bmc_boot_map dut (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .boot_request_pin_n,
      .code_addr, .boot_flash_sel, .reset_vector, .user_loader_addr, .data_pointer_select,
      .double_speed_bit, .usb_tick, .ep0_max_packet);

   // 200 MHz core clock
   always #2.5 clk = ~clk;

   // ****************************************************************
   // Compare, bus and reset tasks
   // ****************************************************************
   task chk_out(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_reg(input logic [7:0] got, input logic [7:0] exp);
      chk_out({8'h00, got}, {8'h00, exp});
   endtask
   // One request held until waitrequest is sampled low, then one idle cycle;
   // a slave that never answers is left to the watchdog
   task bus(input logic wr, input logic [9:0] a, input logic [7:0] v, input logic [3:0] be);
      avs_address <= a; avs_write <= wr; avs_read <= !wr;
      avs_writedata <= {24'h000000, v}; avs_byteenable <= be;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata; rsp = avs_response;
      avs_read <= 1'b0; avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task rdchk(input logic [9:0] a, input logic [7:0] e, input logic [1:0] rs);
      bus(1'b0, a, 8'h00, 4'hF);
      chk_out(rd[15:0], {8'h00, e});
      chk_reg({6'h00, rsp}, {6'h00, rs});
   endtask
   // Write and mirror it in the model; only lane 0 carries data
   task wr(input logic [9:0] a, input logic [7:0] v);
      bus(1'b1, a, v, 4'h1);
      case (a)
         `BMC_ADDR_AUX:    m_aux = v & 8'hFB;
         `BMC_ADDR_HWSEC:  m_hwsec = m_ctrl[0] ? (v | 8'h38) : {v[7:6], m_hwsec[5:0]};
         `BMC_ADDR_UBV:    m_ubv = v;
         `BMC_ADDR_SWPROT: m_swprot = v;
         `BMC_ADDR_CTRL: begin
            if (v[1] && m_ctrl[0]) {m_hwsec, m_ubv, m_swprot} = 24'hFFFFFF;
            m_ctrl = {7'h00, v[0]};
         end
         default: ;
      endcase
   endtask
   // Reset for two cycles with the pin level given, then check the capture
   task rst(input logic p);
      rstn <= 1'b0; boot_request_pin_n <= p;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      boot = !p || !m_hwsec[6];
      m_aux = boot ? 8'h20 : 8'h00;
      // Programming mode is cleared by every reset
      m_ctrl = 8'h00;
      chk_out(reset_vector, boot ? 16'hF000 : 16'h0000);
      chk_out({15'h0, double_speed_bit}, {15'h0, !m_hwsec[7]});
      rdchk(`BMC_ADDR_AUX, m_aux, 2'b00);
      // Pin stays at its level until the next reset; it is looked at once
      rdchk(`BMC_ADDR_STATUS, {5'h00, !p, !m_hwsec[6], !m_hwsec[7]}, 2'b00);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      seed = 84332;
      rst(1'b1);
      rdchk(`BMC_ADDR_HWSEC, 8'hFF, 2'b00);
      rdchk(`BMC_ADDR_UBV, 8'hF0, 2'b00);
      chk_out(user_loader_addr, 16'hF000);
      chk_out({8'h00, ep0_max_packet}, 16'h0020);
      $display("test reset values done");
      for (i = 0; i < 12; i++) begin
         r = $random(seed);
         code_addr <= i[0] ? (r | 16'hF000) : (r & 16'hEFFF);
         d = $random(seed);
         wr(`BMC_ADDR_AUX, d & 8'h2F);
         rdchk(`BMC_ADDR_AUX, m_aux, 2'b00);
         chk_out({15'h0, data_pointer_select}, {15'h0, m_aux[0]});
         chk_out({15'h0, boot_flash_sel}, {15'h0, m_aux[5] && i[0]});
      end
      d = $random(seed);
      wr(`BMC_ADDR_UBV, d);
      repeat (2) @(posedge clk);
      chk_out(user_loader_addr, {d, 8'h00});
      wr(`BMC_ADDR_SWPROT, 8'hFE);
      rdchk(`BMC_ADDR_SWPROT, m_swprot, 2'b00);
      bus(1'b1, 10'h3FC, 8'h55, 4'h1);
      rdchk(10'h3FC, 8'h00, 2'b11);
      bus(1'b1, `BMC_ADDR_UBV, 8'h12, 4'hE);
      rdchk(`BMC_ADDR_UBV, m_ubv, 2'b00);
      $display("test registers done");
      wr(`BMC_ADDR_HWSEC, 8'h38);
      rdchk(`BMC_ADDR_HWSEC, m_hwsec, 2'b00);
      rst(1'b1);
      wr(`BMC_ADDR_CTRL, 8'h01);
      rdchk(`BMC_ADDR_CTRL, m_ctrl, 2'b00);
      wr(`BMC_ADDR_HWSEC, 8'h38);
      rdchk(`BMC_ADDR_HWSEC, m_hwsec, 2'b00);
      wr(`BMC_ADDR_CTRL, 8'h03);
      rdchk(`BMC_ADDR_HWSEC, m_hwsec, 2'b00);
      rdchk(`BMC_ADDR_UBV, m_ubv, 2'b00);
      rdchk(`BMC_ADDR_SWPROT, m_swprot, 2'b00);
      wr(`BMC_ADDR_CTRL, 8'h00);
      $display("test security byte done");
      rst(1'b0);
      rst(1'b1);
      $display("test boot choice done");
      n = 0;
      repeat (1000) begin @(posedge clk); if (usb_tick === 1'b1) n++; end
      chk_out((n >= 239 && n <= 241) ? 16'd240 : n[15:0], 16'd240);
      $display("test rate tick done");
      final_report;
   end

   // Watchdog, well beyond the roughly 1200 cycles the tests need
   initial begin
      #100000;
      mismatches++;
      final_report;
   end
endmodule // bmc_boot_map_bench
